/* ddcwd_top.sv */
`timescale 1ns/10ps
module ddcwd_top (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // converter data pins
  input wire logic [ddcwd_pkg::SAMPLE_W-1:0] chan_a_sample_pins,
  input wire logic [ddcwd_pkg::SAMPLE_W-1:0] chan_b_sample_pins,
  input wire logic ctrl_write_strobe_n,
  input wire logic interleave_select,
  // decoded control state
  output logic full_shutdown_bit,
  output logic converter_on_bit,
  output logic first_filter_on_bit,
  output logic second_filter_on_bit,
  output logic [1:0] pwr_state,
  output logic [1:0] interp_sel,
  output logic [ddcwd_pkg::GAIN_W-1:0] gain_trim,
  // avalon-mm slave
  input wire logic [ddcwd_pkg::ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [ddcwd_pkg::DATA_W-1:0] writedata,
  output logic [ddcwd_pkg::DATA_W-1:0] readdata,
  output logic waitrequest
);

  localparam int SW = ddcwd_pkg::SAMPLE_W;
  localparam int FIFO_CNT_W = $clog2(ddcwd_pkg::FIFO_DEPTH) + 1;

  // control word path
  logic strobe_prev_q, strobe_prev_d;
  logic [SW-1:0] ctrl_word_q, ctrl_word_d;
  logic [ddcwd_pkg::CNT_W-1:0] word_count_q, word_count_d;
  logic strobe_fall;

  // the strobe is seen at rising edges only, so a write must stay low across one edge
  assign strobe_fall = strobe_prev_q & ~ctrl_write_strobe_n;

  always_comb begin
    strobe_prev_d = ctrl_write_strobe_n;
    ctrl_word_d = ctrl_word_q;
    word_count_d = word_count_q;
    if (strobe_fall) begin
      ctrl_word_d = chan_a_sample_pins;
      word_count_d = word_count_q + 1'b1;
    end
  end

  // strobe history resets high so a strobe held low across reset is taken as a write at the first edge
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      strobe_prev_q <= 1'b1;
      ctrl_word_q <= ddcwd_pkg::CTRL_WORD_RESET;
      word_count_q <= '0;
    end else begin
      strobe_prev_q <= strobe_prev_d;
      ctrl_word_q <= ctrl_word_d;
      word_count_q <= word_count_d;
    end
  end

  // pin decode of the latched word
  assign full_shutdown_bit = ctrl_word_q[ddcwd_pkg::PIN_SHUTDOWN];
  assign converter_on_bit = ctrl_word_q[ddcwd_pkg::PIN_CONV_ON];
  assign first_filter_on_bit = ctrl_word_q[ddcwd_pkg::PIN_FILT1];
  assign second_filter_on_bit = ctrl_word_q[ddcwd_pkg::PIN_FILT2];
  // shutdown overrides the enable bit
  assign pwr_state = ddcwd_pkg::ddcwd_power(ctrl_word_q);
  // second filter bit wins even when the host also sets the first one high
  assign interp_sel = ddcwd_pkg::ddcwd_interp(ctrl_word_q);
  assign gain_trim = ctrl_word_q[ddcwd_pkg::PIN_GAIN_HI:ddcwd_pkg::PIN_GAIN_LO];

  // channel B is taken on the falling clock edge
  logic [SW-1:0] b_fall_q;

  always_ff @(negedge ref_clk or posedge reset) begin
    if (reset) begin
      b_fall_q <= '0;
    end else begin
      b_fall_q <= chan_b_sample_pins;
    end
  end

  // sample capture into the fifo
  // interleave pairs the first accepted word as A with the next one as B
  logic half_q, half_d;
  logic [SW-1:0] a_hold_q, a_hold_d;
  logic ovf_q, ovf_d;
  logic cap_en_q, cap_en_d;
  logic sample_slot, push_valid, push_ready;
  logic [ddcwd_pkg::PAIR_W-1:0] push_data;

  // samples flow only while converters run and no control write is in progress
  assign sample_slot = cap_en_q & ctrl_write_strobe_n & strobe_prev_q
    & (pwr_state == ddcwd_pkg::PWR_ACTIVE);

  always_comb begin
    half_d = half_q;
    a_hold_d = a_hold_q;
    push_valid = 1'b0;
    push_data = {b_fall_q, chan_a_sample_pins};
    if (!interleave_select) begin
      half_d = 1'b0;
      push_valid = sample_slot;
    end else if (sample_slot) begin
      half_d = ~half_q;
      if (!half_q) begin
        a_hold_d = chan_a_sample_pins;
      end else begin
        push_valid = 1'b1;
        push_data = {chan_a_sample_pins, a_hold_q};
      end
    end
  end

  // bus interface
  // one wait state: reads load at the first edge, writes land at the second
  logic ack_q, ack_d;
  logic [ddcwd_pkg::DATA_W-1:0] rdata_q, rdata_d;
  logic rd_fire, wr_fire, pop;
  logic fifo_valid;
  logic [ddcwd_pkg::PAIR_W-1:0] fifo_data;
  logic [FIFO_CNT_W-1:0] fifo_count;

  assign rd_fire = read & ~ack_q;
  assign wr_fire = write & ack_q;
  assign waitrequest = (read | write) & ~ack_q;
  assign readdata = rdata_q;
  assign pop = rd_fire & (address == ddcwd_pkg::REG_SAMPLE);

  always_comb begin
    ack_d = (read | write) & ~ack_q;
    cap_en_d = cap_en_q;
    ovf_d = ovf_q;
    rdata_d = rdata_q;
    if (wr_fire && address == ddcwd_pkg::REG_CTRL) begin
      cap_en_d = writedata[ddcwd_pkg::CTRL_CAP_EN];
      if (writedata[ddcwd_pkg::CTRL_OVF_CLR]) begin
        ovf_d = 1'b0;
      end
    end
    // a lost sample in the clearing cycle still sets the flag
    if (push_valid && !push_ready) begin
      ovf_d = 1'b1;
    end
    if (rd_fire) begin
      rdata_d = '0;
      case (address)
        ddcwd_pkg::REG_CTRL: begin
          rdata_d[ddcwd_pkg::CTRL_CAP_EN] = cap_en_q;
        end
        ddcwd_pkg::REG_STATUS: begin
          rdata_d[ddcwd_pkg::ST_WORD_LO +: SW] = ctrl_word_q;
          rdata_d[ddcwd_pkg::ST_PWR_LO +: 2] = pwr_state;
          rdata_d[ddcwd_pkg::ST_INTERP_LO +: 2] = interp_sel;
          rdata_d[ddcwd_pkg::ST_GAIN_LO +: ddcwd_pkg::GAIN_W] = gain_trim;
          rdata_d[ddcwd_pkg::ST_OVF] = ovf_q;
          rdata_d[ddcwd_pkg::ST_COUNT_LO +: FIFO_CNT_W] = fifo_count;
        end
        ddcwd_pkg::REG_SAMPLE: begin
          rdata_d[ddcwd_pkg::PAIR_W-1:0] = fifo_data;
          rdata_d[ddcwd_pkg::SAMPLE_VALID] = fifo_valid;
        end
        ddcwd_pkg::REG_CWCOUNT: begin
          rdata_d[ddcwd_pkg::CNT_W-1:0] = word_count_q;
        end
        default: begin
          rdata_d = '0;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      half_q <= 1'b0;
      a_hold_q <= '0;
      ovf_q <= 1'b0;
      cap_en_q <= ddcwd_pkg::CTRL_CAP_EN_RESET;
      ack_q <= 1'b0;
      rdata_q <= '0;
    end else begin
      half_q <= half_d;
      a_hold_q <= a_hold_d;
      ovf_q <= ovf_d;
      cap_en_q <= cap_en_d;
      ack_q <= ack_d;
      rdata_q <= rdata_d;
    end
  end

  // a pair that meets a full fifo is dropped and flagged
  ddcwd_fifo #(
    .WIDTH(ddcwd_pkg::PAIR_W),
    .DEPTH(ddcwd_pkg::FIFO_DEPTH)
  ) u_fifo (
    .ref_clk(ref_clk),
    .reset(reset),
    .in_valid(push_valid),
    .in_ready(push_ready),
    .in_data(push_data),
    .out_valid(fifo_valid),
    .out_ready(pop),
    .out_data(fifo_data),
    .count(fifo_count)
  );

  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  AST_WORD_LATCH: assert property (
    strobe_fall |=> ctrl_word_q == $past(chan_a_sample_pins))
    else $error("control word not latched on strobe fall");
  AST_WORD_HOLD: assert property (
    !strobe_fall |=> ctrl_word_q == $past(ctrl_word_q))
    else $error("control word changed without strobe fall");
  AST_WORD_COUNT: assert property (
    strobe_fall |=> word_count_q == $past(word_count_q) + 1'b1)
    else $error("control write not counted");
  AST_SHUTDOWN: assert property (
    strobe_fall && chan_a_sample_pins[ddcwd_pkg::PIN_SHUTDOWN]
    |=> pwr_state == ddcwd_pkg::PWR_DOWN && full_shutdown_bit)
    else $error("shutdown bit did not power down");
  AST_SHUTDOWN_PIN: assert property (
    strobe_fall |=> full_shutdown_bit == $past(chan_a_sample_pins[9]))
    else $error("shutdown bit not taken from pin 9");
  AST_STANDBY: assert property (
    strobe_fall && chan_a_sample_pins[9:8] == 2'b00 |=> pwr_state == ddcwd_pkg::PWR_STANDBY)
    else $error("standby not entered");
  AST_ACTIVE: assert property (
    strobe_fall && chan_a_sample_pins[9:8] == 2'b01 |=> pwr_state == ddcwd_pkg::PWR_ACTIVE)
    else $error("converters not powered up");
  AST_ENABLE_PIN: assert property (
    strobe_fall |=> converter_on_bit == $past(chan_a_sample_pins[8]))
    else $error("enable bit not taken from pin 8");
  AST_FILT_PINS: assert property (
    strobe_fall |=> {second_filter_on_bit, first_filter_on_bit} == $past(chan_a_sample_pins[7:6]))
    else $error("filter bits not taken from pins 7 and 6");
  AST_INTERP_2X: assert property (
    ctrl_word_q[7:6] == 2'b01 |-> interp_sel == ddcwd_pkg::INTERP_2X)
    else $error("2x interpolation not selected");
  AST_INTERP_4X: assert property (
    strobe_fall && chan_a_sample_pins[7] |=> interp_sel == ddcwd_pkg::INTERP_4X)
    else $error("4x interpolation not selected");
  AST_INTERP_F1: assert property (
    !ctrl_word_q[7] |-> interp_sel == (ctrl_word_q[6] ? ddcwd_pkg::INTERP_2X : ddcwd_pkg::INTERP_1X))
    else $error("interpolation not from first filter bit");
  AST_GAIN: assert property (
    strobe_fall |=> gain_trim == $past(chan_a_sample_pins[5:2]))
    else $error("gain trim taken from wrong pins");
  AST_SPLIT_PHASE: assert property (
    !interleave_select |=> !half_q)
    else $error("interleave phase kept in split mode");
  AST_HALF_HOLD: assert property (
    interleave_select && !sample_slot |=> half_q == $past(half_q))
    else $error("interleave phase moved without a sample");
  AST_NO_SAMPLE_IDLE: assert property (
    pwr_state != ddcwd_pkg::PWR_ACTIVE |-> !push_valid)
    else $error("sample pushed while converters not active");
  AST_CAP_OFF: assert property (
    !cap_en_q |-> !push_valid)
    else $error("sample pushed with capture disabled");
  AST_OVF_STICKY: assert property (
    push_valid && !push_ready |=> ovf_q)
    else $error("lost sample did not set overflow");
  AST_RDATA_HOLD: assert property (
    !(read && !ack_q) |=> readdata == $past(readdata))
    else $error("read data changed without a read");
  AST_SPLIT: assert property (
    push_valid && !interleave_select |-> push_data == {b_fall_q, chan_a_sample_pins})
    else $error("split mode pair wrong");
  AST_INTERLEAVE: assert property (
    push_valid && interleave_select ##0 $past(sample_slot && interleave_select)
    |-> push_data == {chan_a_sample_pins, $past(chan_a_sample_pins)})
    else $error("interleave pair wrong");
  AST_NO_SAMPLE_ON_STROBE: assert property (
    !ctrl_write_strobe_n |-> !push_valid)
    else $error("sample pushed during control write");
  AST_BUS_ANSWER: assert property (
    (read || write) && !ack_q |=> !waitrequest)
    else $error("bus answer late");

  COV_WORD_WRITE: cover property (strobe_fall ##1 pwr_state == ddcwd_pkg::PWR_ACTIVE);
  COV_STANDBY_WRITE: cover property (strobe_fall ##1 pwr_state == ddcwd_pkg::PWR_STANDBY);
  COV_INTERLEAVE_PUSH: cover property (push_valid && interleave_select);
  COV_OVERFLOW: cover property (push_valid && !push_ready);
  COV_SAMPLE_READ: cover property (pop && fifo_valid);

endmodule : ddcwd_top

/* ddcwd_pkg.sv */
package ddcwd_pkg;

  // pin and word widths
  localparam int SAMPLE_W = 10;
  localparam int GAIN_W = 4;
  localparam int PAIR_W = 2 * SAMPLE_W;
  localparam int FIFO_DEPTH = 16;
  localparam int ADDR_W = 5;
  localparam int DATA_W = 32;
  localparam int CNT_W = 16;

  // control word positions on the channel A pins
  localparam int PIN_SHUTDOWN = 9;
  localparam int PIN_CONV_ON = 8;
  localparam int PIN_FILT2 = 7;
  localparam int PIN_FILT1 = 6;
  localparam int PIN_GAIN_HI = 5;
  localparam int PIN_GAIN_LO = 2;

  // register byte offsets
  localparam logic [ADDR_W-1:0] REG_CTRL = 5'h00;
  localparam logic [ADDR_W-1:0] REG_STATUS = 5'h04;
  localparam logic [ADDR_W-1:0] REG_SAMPLE = 5'h08;
  localparam logic [ADDR_W-1:0] REG_CWCOUNT = 5'h0C;

  // control register fields and reset values
  localparam int CTRL_CAP_EN = 0;
  localparam int CTRL_OVF_CLR = 1;
  localparam logic CTRL_CAP_EN_RESET = 1'b1;
  localparam logic [SAMPLE_W-1:0] CTRL_WORD_RESET = 10'h000;

  // status and sample register fields
  localparam int ST_WORD_LO = 0;
  localparam int ST_PWR_LO = 10;
  localparam int ST_INTERP_LO = 12;
  localparam int ST_GAIN_LO = 14;
  localparam int ST_OVF = 18;
  localparam int ST_COUNT_LO = 19;
  localparam int SAMPLE_VALID = 31;

  typedef enum logic [1:0] {PWR_DOWN, PWR_STANDBY, PWR_ACTIVE} ddcwd_pwr_e;
  typedef enum logic [1:0] {INTERP_1X, INTERP_2X, INTERP_4X} ddcwd_interp_e;

  function automatic ddcwd_pwr_e ddcwd_power(input logic [SAMPLE_W-1:0] ctrl_word);
    if (ctrl_word[PIN_SHUTDOWN]) begin
      return PWR_DOWN;
    end else if (ctrl_word[PIN_CONV_ON]) begin
      return PWR_ACTIVE;
    end
    return PWR_STANDBY;
  endfunction : ddcwd_power

  function automatic ddcwd_interp_e ddcwd_interp(input logic [SAMPLE_W-1:0] ctrl_word);
    if (ctrl_word[PIN_FILT2]) begin
      return INTERP_4X;
    end else if (ctrl_word[PIN_FILT1]) begin
      return INTERP_2X;
    end
    return INTERP_1X;
  endfunction : ddcwd_interp

endpackage : ddcwd_pkg

/* ddcwd_fifo.sv */
`timescale 1ns/10ps
module ddcwd_fifo #(
  parameter int WIDTH = 20,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  // fill level
  output logic [$clog2(DEPTH):0] count
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [WIDTH-1:0] mem_d [DEPTH];
  logic [PW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [PW:0] cnt_q, cnt_d;
  logic push, pop;

  assign in_ready = (cnt_q != (PW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rd_q];
  assign count = cnt_q;
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always_comb begin
    mem_d = mem_q;
    wr_d = wr_q;
    rd_d = rd_q;
    cnt_d = cnt_q;
    if (push) begin
      mem_d[wr_q] = in_data;
      wr_d = (wr_q == PW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
    end
    if (pop) begin
      rd_d = (rd_q == PW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
    end
    if (push && !pop) begin
      cnt_d = cnt_q + 1'b1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= '0;
      end
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      mem_q <= mem_d;
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  AST_FIFO_BOUND: assert property (cnt_q <= (PW+1)'(DEPTH))
    else $error("fifo count above depth");
  AST_FIFO_FULL_STALL: assert property (!in_ready && in_valid && !pop |=> cnt_q == $past(cnt_q))
    else $error("fifo accepted data while full");

endmodule : ddcwd_fifo

/* ddcwd_host_model.sv */
`timescale 1ns/10ps
module ddcwd_host_model (
  // clock
  input wire logic ref_clk,
  // converter data pins
  output logic [ddcwd_pkg::SAMPLE_W-1:0] chan_a_sample_pins,
  output logic [ddcwd_pkg::SAMPLE_W-1:0] chan_b_sample_pins,
  output logic ctrl_write_strobe_n
);
  int seed = 32'hae31;
  logic [ddcwd_pkg::SAMPLE_W-1:0] pend_word = 10'h000;
  logic word_pend = 1'b0;

  initial begin
    chan_a_sample_pins = 10'h000;
    chan_b_sample_pins = 10'h000;
    ctrl_write_strobe_n = 1'b1;
  end

  // fresh samples every rising edge, except on a while it carries a pending word; the device takes b on the falling edge
  always @(posedge ref_clk) begin
    chan_b_sample_pins <= 10'($random(seed));
    if (word_pend) begin
      chan_a_sample_pins <= pend_word;
      ctrl_write_strobe_n <= 1'b0;
      word_pend <= 1'b0;
    end else begin
      ctrl_write_strobe_n <= 1'b1;
      chan_a_sample_pins <= 10'($random(seed));
    end
  end

  // call right after a rising edge; returns once the strobe is high again
  task send_word(input logic [ddcwd_pkg::SAMPLE_W-1:0] w);
    pend_word <= w;
    word_pend <= 1'b1;
    repeat (3) @(posedge ref_clk);
  endtask : send_word
endmodule : ddcwd_host_model

/* test_ddcwd_top.sv */
`timescale 1ns/10ps
module test_ddcwd_top;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic interleave_select = 1'b0;
  logic [ddcwd_pkg::ADDR_W-1:0] address = 5'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0000_0000;
  logic [9:0] chan_a_sample_pins;
  logic [9:0] chan_b_sample_pins;
  logic ctrl_write_strobe_n;
  logic full_shutdown_bit;
  logic converter_on_bit;
  logic first_filter_on_bit;
  logic second_filter_on_bit;
  logic [1:0] pwr_state;
  logic [1:0] interp_sel;
  logic [3:0] gain_trim;
  logic [31:0] readdata;
  logic waitrequest;
  int mismatches = 0;
  int total_checks = 0;
  int cycles = 0;
  int word_writes = 0;
  int seed = 32'hae31;
  logic [9:0] exp_word = 10'h000;
  logic [9:0] b_fall = 10'h000;
  logic [9:0] a_hold = 10'h000;
  logic phase = 1'b0;
  logic prev_n = 1'b1;
  logic cap_en = 1'b1;
  logic ovf = 1'b0;
  logic [19:0] q[$];
  logic [31:0] rd;
  logic [3:0] hi_tab [8] = '{4'h8, 4'hf, 4'h0, 4'h1, 4'h3, 4'h4, 4'h5, 4'h7};

  always #10 ref_clk = ~ref_clk;

  ddcwd_host_model ddcwd_host_model_i (
    .ref_clk(ref_clk), .chan_a_sample_pins(chan_a_sample_pins),
    .chan_b_sample_pins(chan_b_sample_pins), .ctrl_write_strobe_n(ctrl_write_strobe_n));

  ddcwd_top ddcwd_top_i (
    .ref_clk(ref_clk), .reset(reset), .chan_a_sample_pins(chan_a_sample_pins),
    .chan_b_sample_pins(chan_b_sample_pins), .ctrl_write_strobe_n(ctrl_write_strobe_n),
    .interleave_select(interleave_select), .full_shutdown_bit(full_shutdown_bit),
    .converter_on_bit(converter_on_bit), .first_filter_on_bit(first_filter_on_bit),
    .second_filter_on_bit(second_filter_on_bit), .pwr_state(pwr_state), .interp_sel(interp_sel),
    .gain_trim(gain_trim), .address(address), .read(read), .write(write), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest));

  function automatic logic [1:0] exp_pwr(input logic [9:0] w);
    return w[9] ? 2'd0 : (w[8] ? 2'd2 : 2'd1);
  endfunction : exp_pwr

  function automatic logic [1:0] exp_interp(input logic [9:0] w);
    return w[7] ? 2'd2 : (w[6] ? 2'd1 : 2'd0);
  endfunction : exp_interp

  function automatic logic [31:0] exp_status(input logic [9:0] w);
    return {8'h00, 5'(q.size()), ovf, w[5:2], exp_interp(w), exp_pwr(w), w};
  endfunction : exp_status

  task test_done();
    if (mismatches == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : test_done

  task chk(input string name, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", name, e, g);
    end
  endtask : chk

  // one avalon transfer; called right after a rising edge
  task bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    address <= a;
    writedata <= d;
    read <= !wr;
    write <= wr;
    do @(posedge ref_clk); while (waitrequest !== 1'b0);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge ref_clk);
  endtask : bus

  task ctrl_write(input logic [9:0] w);
    ddcwd_host_model_i.send_word(w);
    exp_word = w;
    word_writes++;
  endtask : ctrl_write

  task push(input logic [19:0] v);
    if (q.size() < 16) q.push_back(v);
    else ovf = 1'b1;
  endtask : push

  task chk_outs();
    chk("shutdown", exp_word[9], full_shutdown_bit);
    chk("conv_on", exp_word[8], converter_on_bit);
    chk("filt2", exp_word[7], second_filter_on_bit);
    chk("filt1", exp_word[6], first_filter_on_bit);
    chk("pwr", exp_pwr(exp_word), pwr_state);
    chk("interp", exp_interp(exp_word), interp_sel);
    chk("gain", exp_word[5:2], gain_trim);
  endtask : chk_outs

  task chk_status();
    bus(1'b0, ddcwd_pkg::REG_STATUS, 32'h0000_0000);
    chk("status", exp_status(exp_word), rd);
  endtask : chk_status

  task drain();
    repeat (17) begin
      bus(1'b0, ddcwd_pkg::REG_SAMPLE, 32'h0000_0000);
      if (q.size() > 0) chk("sample", {1'b1, q.pop_front()}, {rd[31], rd[19:0]});
      else chk("sample_valid", 32'h0000_0000, rd[31]);
    end
  endtask : drain

  // reference capture of the sample stream
  always @(negedge ref_clk) b_fall <= chan_b_sample_pins;

  always @(posedge ref_clk) begin
    if (reset) begin
      prev_n = 1'b1;
    end else begin
      if (write && waitrequest === 1'b0 && address == ddcwd_pkg::REG_CTRL && writedata[1]) ovf = 1'b0;
      if (!interleave_select) phase = 1'b0;
      if (ctrl_write_strobe_n && prev_n && cap_en && exp_pwr(exp_word) == 2'd2) begin
        if (!interleave_select) push({b_fall, chan_a_sample_pins});
        else if (!phase) begin
          a_hold = chan_a_sample_pins;
          phase = 1'b1;
        end else begin
          push({chan_a_sample_pins, a_hold});
          phase = 1'b0;
        end
      end
      // a new capture enable governs only the edges after the write
      if (write && waitrequest === 1'b0 && address == ddcwd_pkg::REG_CTRL) cap_en = writedata[0];
      prev_n = ctrl_write_strobe_n;
    end
  end

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      test_done();
    end
  end

  initial begin
    repeat (10) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    bus(1'b0, ddcwd_pkg::REG_CTRL, 32'h0000_0000);
    chk("ctrl", 32'h0000_0001, rd);
    chk_outs();
    bus(1'b1, 5'h10, 32'hffff_ffff);
    bus(1'b0, 5'h10, 32'h0000_0000);
    chk("unmapped", 32'h0000_0000, rd);
    bus(1'b1, ddcwd_pkg::REG_STATUS, 32'hffff_ffff);
    chk_status();
    // split stream until the fifo refuses
    ctrl_write(10'h13c);
    repeat (20) @(posedge ref_clk);
    chk_outs();
    ctrl_write(10'h000);
    chk_status();
    drain();
    bus(1'b1, ddcwd_pkg::REG_CTRL, 32'h0000_0003);
    chk_status();
    // both channels through port a
    interleave_select <= 1'b1;
    ctrl_write(10'h1c4);
    repeat (9) @(posedge ref_clk);
    ctrl_write(10'h000);
    interleave_select <= 1'b0;
    drain();
    // capture disabled keeps the fifo empty
    bus(1'b1, ddcwd_pkg::REG_CTRL, 32'h0000_0000);
    ctrl_write(10'h100);
    repeat (5) @(posedge ref_clk);
    ctrl_write(10'h000);
    chk_status();
    for (int k = 0; k < 8; k++) begin
      ctrl_write({hi_tab[k], 4'($random(seed)), 2'($random(seed))});
      chk_outs();
      chk_status();
    end
    bus(1'b0, ddcwd_pkg::REG_CWCOUNT, 32'h0000_0000);
    chk("word_count", 32'(word_writes), rd);
    test_done();
  end
endmodule : test_ddcwd_top
